//--- design/isr_routing.sv
// Purpose: event flag registers and two active-low interrupt pins
// Assumes: AXI4-Lite master on ref_clk, event levels asynchronous
// Notes: registers sit in bits 7:0 of each word, upper bits read zero
// Functional notes
// (RL1) clock flags: DLL lost 5, locked 4, PLL 1, 0
// (RL2) converter-1 flags: cal done 3, amp error 0
// (RL3) converter-0 flags: cal done 3, amp error 0
// (RL4) enable low: flag shows live source state
// (RL5) enable high: occurrence latches flag, drives pin
// (RL6) writing one clears latched flag; zero ignored
// (RL7) select zero routes to pin A, one B
// (RL8) link select bits: sysref, ready, fifo, prbs
// (RL9) disabled event reaches neither pin
// (RL10) per-event enable registers, reset to zero
// (RL11) converter selects share their flags' bit positions
// (RL12) pin low while any routed latched flag pending
// (RL13) reset and reserved bits read as zero
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module isr_routing (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [isr_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [isr_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [isr_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [isr_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    input wire isr_pkg::isr_grp_t eventLevel,
    output logic interruptPinA_n,
    output logic interruptPinB_n
);
    isr_pkg::isr_grp_t liveQ, latchQ, clearReq, flagView;
    isr_pkg::isr_grp_t enQ, enD, selQ, selD;
    isr_pkg::isr_chan_t wState_q, wState_d, rState_q, rState_d;
    logic awGot_q, awGot_d, wGot_q, wGot_d, wLane_q, wLane_d;
    logic [isr_pkg::ADDR_W-1:0] awAddr_q, awAddr_d;
    logic [isr_pkg::REG_W-1:0] wData_q, wData_d, rdByte;
    logic awReady_q, awReady_d, wReady_q, wReady_d;
    logic bValid_q, bValid_d, arReady_q, arReady_d, rValid_q, rValid_d;
    logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
    logic [isr_pkg::DATA_W-1:0] rData_q, rData_d;
    logic wrFire, wrHit, rdHit, pinA_d, pinB_d, pinA_q, pinB_q;
    logic anyA, anyB;

    // event levels onto ref_clk
    isr_sync3 uSync (
        .ref_clk(ref_clk),
        .rst(rst),
        .rawIn(eventLevel),
        .stableOut(liveQ)
    );

    // latched flags per event
    isr_flag_bank uFlags (
        .ref_clk(ref_clk),
        .rst(rst),
        .liveIn(liveQ),
        .enableIn(enQ),
        .clearIn(clearReq),
        .latchOut(latchQ)
    );

    // (RL4) readback: live when disabled, latched when enabled
    assign flagView = ((enQ & latchQ) | (~enQ & liveQ)) & isr_pkg::GRP_MASK;

    // decode of the captured write address
    always_comb begin
        case (awAddr_q[7:2])
            isr_pkg::IDX_CONV0_EN,
            isr_pkg::IDX_CONV1_EN,
            isr_pkg::IDX_CLOCK_EN,
            isr_pkg::IDX_LINK_EN,
            isr_pkg::IDX_LINK_FLAGS,
            isr_pkg::IDX_CONV0_FLAGS,
            isr_pkg::IDX_CONV1_FLAGS,
            isr_pkg::IDX_CLOCK_FLAGS,
            isr_pkg::IDX_LINK_SEL,
            isr_pkg::IDX_CONV0_SEL,
            isr_pkg::IDX_CONV1_SEL,
            isr_pkg::IDX_CLOCK_SEL: wrHit = 1'b1;
            default: wrHit = 1'b0;
        endcase
    end

    // write channel: address and data in either order, then response
    always_comb begin
        wState_d = wState_q;
        awGot_d = awGot_q;
        wGot_d = wGot_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wLane_d = wLane_q;
        bValid_d = bValid_q;
        bResp_d = bResp_q;
        wrFire = 1'b0;
        case (wState_q)
            isr_pkg::CH_IDLE: begin
                if (awvalid && awReady_q) begin
                    awGot_d = 1'b1;
                    awAddr_d = awaddr;
                end
                if (wvalid && wReady_q) begin
                    wGot_d = 1'b1;
                    wData_d = wdata[7:0];
                    wLane_d = wstrb[0];
                end
                if (awGot_q && wGot_q) begin
                    wrFire = 1'b1;
                    awGot_d = 1'b0;
                    wGot_d = 1'b0;
                    bValid_d = 1'b1;
                    bResp_d = wrHit ? isr_pkg::RESP_OKAY : isr_pkg::RESP_SLVERR;
                    wState_d = isr_pkg::CH_RESP;
                end
            end
            isr_pkg::CH_RESP: begin
                if (bready) begin
                    bValid_d = 1'b0;
                    wState_d = isr_pkg::CH_IDLE;
                end
            end
            default: begin
                bValid_d = 1'b0;
                wState_d = isr_pkg::CH_IDLE;
            end
        endcase
        awReady_d = (wState_d == isr_pkg::CH_IDLE) && !awGot_d;
        wReady_d = (wState_d == isr_pkg::CH_IDLE) && !wGot_d;
    end

    // write channel registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wState_q <= isr_pkg::CH_IDLE;
            awGot_q <= 1'b0;
            wGot_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= isr_pkg::REG_RST;
            wLane_q <= 1'b0;
            awReady_q <= 1'b0;
            wReady_q <= 1'b0;
            bValid_q <= 1'b0;
            bResp_q <= isr_pkg::RESP_OKAY;
        end else begin
            wState_q <= wState_d;
            awGot_q <= awGot_d;
            wGot_q <= wGot_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wLane_q <= wLane_d;
            awReady_q <= awReady_d;
            wReady_q <= wReady_d;
            bValid_q <= bValid_d;
            bResp_q <= bResp_d;
        end
    end

    // register effects of an accepted write; reserved bits never stored
    always_comb begin
        enD = enQ;
        selD = selQ;
        clearReq = isr_pkg::GRP_RST;
        if (wrFire && wLane_q) begin
            case (awAddr_q[7:2])
                // (RL10) enables pick live or latched mode
                isr_pkg::IDX_CONV0_EN: enD.conv0 = wData_q & isr_pkg::MASK_CONV;
                isr_pkg::IDX_CONV1_EN: enD.conv1 = wData_q & isr_pkg::MASK_CONV;
                isr_pkg::IDX_CLOCK_EN: enD.clock = wData_q & isr_pkg::MASK_CLOCK;
                isr_pkg::IDX_LINK_EN: enD.link = wData_q & isr_pkg::MASK_LINK;
                // (RL6) write one clears only latched flags
                isr_pkg::IDX_CONV0_FLAGS:
                    clearReq.conv0 = wData_q & isr_pkg::MASK_CONV & enQ.conv0;
                isr_pkg::IDX_CONV1_FLAGS:
                    clearReq.conv1 = wData_q & isr_pkg::MASK_CONV & enQ.conv1;
                isr_pkg::IDX_CLOCK_FLAGS:
                    clearReq.clock = wData_q & isr_pkg::MASK_CLOCK & enQ.clock;
                isr_pkg::IDX_LINK_FLAGS:
                    clearReq.link = wData_q & isr_pkg::MASK_LINK & enQ.link;
                // (RL8) link selects in bits 4..0
                isr_pkg::IDX_LINK_SEL: selD.link = wData_q & isr_pkg::MASK_LINK;
                // (RL11) converter selects at flag positions
                isr_pkg::IDX_CONV0_SEL: selD.conv0 = wData_q & isr_pkg::MASK_CONV;
                isr_pkg::IDX_CONV1_SEL: selD.conv1 = wData_q & isr_pkg::MASK_CONV;
                isr_pkg::IDX_CLOCK_SEL: selD.clock = wData_q & isr_pkg::MASK_CLOCK;
                default: clearReq = isr_pkg::GRP_RST;
            endcase
        end
    end

    // (RL10) (RL13) enables and selects reset to zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            enQ <= isr_pkg::GRP_RST;
            selQ <= isr_pkg::GRP_RST;
        end else begin
            enQ <= enD;
            selQ <= selD;
        end
    end

    // read decode; (RL1) (RL2) (RL3) (RL13) masked flag layouts
    always_comb begin
        rdByte = isr_pkg::REG_RST;
        rdHit = 1'b1;
        case (araddr[7:2])
            isr_pkg::IDX_CONV0_EN: rdByte = enQ.conv0;
            isr_pkg::IDX_CONV1_EN: rdByte = enQ.conv1;
            isr_pkg::IDX_CLOCK_EN: rdByte = enQ.clock;
            isr_pkg::IDX_LINK_EN: rdByte = enQ.link;
            isr_pkg::IDX_CONV0_FLAGS: rdByte = flagView.conv0;
            isr_pkg::IDX_CONV1_FLAGS: rdByte = flagView.conv1;
            isr_pkg::IDX_CLOCK_FLAGS: rdByte = flagView.clock;
            isr_pkg::IDX_LINK_FLAGS: rdByte = flagView.link;
            isr_pkg::IDX_CONV0_SEL: rdByte = selQ.conv0;
            isr_pkg::IDX_CONV1_SEL: rdByte = selQ.conv1;
            isr_pkg::IDX_CLOCK_SEL: rdByte = selQ.clock;
            isr_pkg::IDX_LINK_SEL: rdByte = selQ.link;
            default: rdHit = 1'b0;
        endcase
    end

    // read channel: one word answered the cycle after acceptance
    always_comb begin
        rState_d = rState_q;
        rValid_d = rValid_q;
        rData_d = rData_q;
        rResp_d = rResp_q;
        case (rState_q)
            isr_pkg::CH_IDLE: begin
                if (arvalid && arReady_q) begin
                    rValid_d = 1'b1;
                    rData_d = {isr_pkg::UPPER_ZERO, rdByte};
                    rResp_d = rdHit ? isr_pkg::RESP_OKAY : isr_pkg::RESP_SLVERR;
                    rState_d = isr_pkg::CH_RESP;
                end
            end
            isr_pkg::CH_RESP: begin
                if (rready) begin
                    rValid_d = 1'b0;
                    rState_d = isr_pkg::CH_IDLE;
                end
            end
            default: begin
                rValid_d = 1'b0;
                rState_d = isr_pkg::CH_IDLE;
            end
        endcase
        arReady_d = (rState_d == isr_pkg::CH_IDLE);
    end

    // read channel registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rState_q <= isr_pkg::CH_IDLE;
            arReady_q <= 1'b0;
            rValid_q <= 1'b0;
            rData_q <= 32'h00000000;
            rResp_q <= isr_pkg::RESP_OKAY;
        end else begin
            rState_q <= rState_d;
            arReady_q <= arReady_d;
            rValid_q <= rValid_d;
            rData_q <= rData_d;
            rResp_q <= rResp_d;
        end
    end

    // (RL7) (RL9) route enabled latched flags by select bit
    assign anyA = |(latchQ & enQ & ~selQ);
    assign anyB = |(latchQ & enQ & selQ);

    // (RL12) pin low while any routed flag is pending
    always_comb begin
        pinA_d = ~anyA;
        pinB_d = ~anyB;
    end

    // pin registers, released at reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pinA_q <= 1'b1;
            pinB_q <= 1'b1;
        end else begin
            pinA_q <= pinA_d;
            pinB_q <= pinB_d;
        end
    end

    assign awready = awReady_q;
    assign wready = wReady_q;
    assign bvalid = bValid_q;
    assign bresp = bResp_q;
    assign arready = arReady_q;
    assign rvalid = rValid_q;
    assign rdata = rData_q;
    assign rresp = rResp_q;
    assign interruptPinA_n = pinA_q;
    assign interruptPinB_n = pinB_q;

    chk_pin_a_drive: assert property (@(posedge ref_clk) disable iff (rst) // (RL7)
        anyA |=> !interruptPinA_n)
        else $error("pin A not driven for routed flag");
    chk_pin_release: assert property (@(posedge ref_clk) disable iff (rst) // (RL12)
        !anyB |=> interruptPinB_n)
        else $error("pin B held low with nothing pending");
    chk_disabled_silent: assert property (@(posedge ref_clk) disable iff (rst) // (RL9)
        (enQ == 0) |=> (interruptPinA_n && interruptPinB_n))
        else $error("disabled event reached a pin");
    chk_live_readback: assert property (@(posedge ref_clk) disable iff (rst) // (RL4)
        (arvalid && arReady_q && araddr[7:2] == isr_pkg::IDX_CONV0_FLAGS
            && enQ.conv0 == 0)
        |=> rData_q[7:0] == ($past(liveQ.conv0) & isr_pkg::MASK_CONV))
        else $error("disabled flag did not read live status");
    chk_clock_layout: assert property (@(posedge ref_clk) disable iff (rst) // (RL1)
        (arvalid && arReady_q && araddr[7:2] == isr_pkg::IDX_CLOCK_FLAGS)
        |=> ((rData_q & ~32'h00000033) == 0) && rResp_q == isr_pkg::RESP_OKAY)
        else $error("clock flag reserved bits not zero");
    chk_link_select: assert property (@(posedge ref_clk) disable iff (rst) // (RL8)
        (wrFire && wLane_q && awAddr_q[7:2] == isr_pkg::IDX_LINK_SEL)
        |=> bValid_q && selQ.link == ($past(wData_q) & isr_pkg::MASK_LINK))
        else $error("link select write not stored");
    chk_enable_reset: assert property (@(posedge ref_clk) // (RL10)
        $fell(rst) |-> (enQ == 0 && selQ == 0 && interruptPinA_n))
        else $error("enables not zero after reset");
endmodule // isr_routing

`default_nettype wire

//--- design/isr_pkg.sv
// Purpose: shared constants and types of the interrupt status and routing block
// Assumes: 32-bit AXI4-Lite data, 8-bit registers in the low byte of each word
// Notes: byte address of a register is its index times four
package isr_pkg;
    // widths
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned REG_W = 8;
    localparam int unsigned GRP_W = 32;
    // register indices
    localparam logic [5:0] IDX_CONV0_EN = 6'h21;
    localparam logic [5:0] IDX_CONV1_EN = 6'h22;
    localparam logic [5:0] IDX_CLOCK_EN = 6'h23;
    localparam logic [5:0] IDX_LINK_FLAGS = 6'h24;
    localparam logic [5:0] IDX_CONV0_FLAGS = 6'h25;
    localparam logic [5:0] IDX_CONV1_FLAGS = 6'h26;
    localparam logic [5:0] IDX_CLOCK_FLAGS = 6'h27;
    localparam logic [5:0] IDX_LINK_SEL = 6'h28;
    localparam logic [5:0] IDX_CONV0_SEL = 6'h29;
    localparam logic [5:0] IDX_CONV1_SEL = 6'h2A;
    localparam logic [5:0] IDX_CLOCK_SEL = 6'h2B;
    localparam logic [5:0] IDX_LINK_EN = 6'h2C;
    // implemented bits per group
    localparam logic [7:0] MASK_CONV = 8'h09;
    localparam logic [7:0] MASK_CLOCK = 8'h33;
    localparam logic [7:0] MASK_LINK = 8'h1F;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [23:0] UPPER_ZERO = 24'h000000;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // one byte per event group
    typedef struct packed {
        logic [7:0] link;
        logic [7:0] clock;
        logic [7:0] conv1;
        logic [7:0] conv0;
    } isr_grp_t;
    localparam isr_grp_t GRP_MASK = '{link: MASK_LINK, clock: MASK_CLOCK,
        conv1: MASK_CONV, conv0: MASK_CONV};
    localparam isr_grp_t GRP_RST = '{link: REG_RST, clock: REG_RST,
        conv1: REG_RST, conv0: REG_RST};
    // channel states, one-hot
    typedef enum logic [1:0] {
        CH_IDLE = 2'h1,
        CH_RESP = 2'h2
    } isr_chan_t;
endpackage

//--- design/isr_sync3.sv
// Purpose: bring asynchronous event levels onto ref_clk
// Assumes: sources may change at any time
// Notes: a change is taken once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none

module isr_sync3 (
    input wire logic ref_clk,
    input wire logic rst,
    input wire isr_pkg::isr_grp_t rawIn,
    output isr_pkg::isr_grp_t stableOut
);
    logic [isr_pkg::GRP_W-1:0] s1_q, s2_q, s3_q, out_q, out_d;

    // keep the old value while the last two stages disagree
    always_comb begin
        out_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_q);
    end

    // stage one feeds stage two only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_q <= isr_pkg::GRP_RST;
            s2_q <= isr_pkg::GRP_RST;
            s3_q <= isr_pkg::GRP_RST;
            out_q <= isr_pkg::GRP_RST;
        end else begin
            s1_q <= rawIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign stableOut = out_q;
endmodule // isr_sync3

`default_nettype wire

//--- design/isr_flag_bank.sv
// Purpose: latched event flags, one per implemented bit of each group
// Assumes: live levels already synchronised, clear is a one-cycle pulse
// Notes: an occurrence is a rising edge of the live level
`timescale 1ns/1ps
`default_nettype none

module isr_flag_bank (
    input wire logic ref_clk,
    input wire logic rst,
    input wire isr_pkg::isr_grp_t liveIn,
    input wire isr_pkg::isr_grp_t enableIn,
    input wire isr_pkg::isr_grp_t clearIn,
    output isr_pkg::isr_grp_t latchOut
);
    logic [isr_pkg::GRP_W-1:0] prev_q, latch_q, latch_d, setVec, enV, clrV;

    assign enV = enableIn;
    assign clrV = clearIn;
    // rising edge of an enabled, implemented source
    assign setVec = enV & liveIn & ~prev_q & isr_pkg::GRP_MASK;

    genvar i;
    for (i = 0; i < isr_pkg::GRP_W; i++) begin : gBit
        // (RL5) latch on occurrence; (RL6) clear, set wins
        always_comb begin
            if (enV[i]) begin
                latch_d[i] = setVec[i] | (latch_q[i] & ~clrV[i]);
            end else begin
                // (RL4) live mode holds nothing
                latch_d[i] = 1'b0;
            end
        end
    end

    // flag and edge history registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev_q <= isr_pkg::GRP_RST;
            latch_q <= isr_pkg::GRP_RST;
        end else begin
            prev_q <= liveIn;
            latch_q <= latch_d;
        end
    end

    assign latchOut = latch_q;

    chk_latch_on_event: assert property (@(posedge ref_clk) disable iff (rst) // (RL5)
        (setVec != 0) |=> ((latch_q & $past(setVec)) == $past(setVec)))
        else $error("enabled event did not latch its flag");
    chk_clear_by_one: assert property (@(posedge ref_clk) disable iff (rst) // (RL6)
        ((clrV & ~setVec) != 0) |=> ((latch_q & $past(clrV & ~setVec)) == 0))
        else $error("write of one did not clear latched flag");
    chk_live_no_latch: assert property (@(posedge ref_clk) disable iff (rst) // (RL4)
        1'b1 |=> ((latch_q & ~$past(enV)) == 0))
        else $error("flag latched while its enable was low");
endmodule // isr_flag_bank

`default_nettype wire

//--- tb/isr_host_model.sv
// Purpose: host processor side that watches the two interrupt pins
// Assumes: pins are push-pull and active low
// Notes: pending bits show the pins one ref_clk edge late
`timescale 1ns/1ps
`default_nettype none

module isr_host_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pinA_n,
    input wire logic pinB_n,
    output logic [1:0] pending
);
    logic [1:0] pend_d;
    logic [1:0] pend_q;

    always_comb begin
        pend_d = {~pinB_n, ~pinA_n};
    end

    // sample pins, nothing pending in reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pend_q <= 2'b00;
        end else begin
            pend_q <= pend_d;
        end
    end

    assign pending = pend_q; // bit 0 pin A, bit 1 pin B
endmodule // isr_host_model
`default_nettype wire

//--- tb/irq_status_routing_tb.sv
// Purpose: self-checking bench of the interrupt status and routing block
// Assumes: AXI4-Lite master on ref_clk, event levels driven on clock edges
// Notes: bus answers are queued by the driver and checked by a monitor
`timescale 1ns/1ps
`default_nettype none

module irq_status_routing_tb;
    logic ref_clk;
    logic rst;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pinA_n, pinB_n;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hF;
    logic [31:0] rdata;
    logic [1:0] bresp, rresp, pend;
    isr_pkg::isr_grp_t ev = '0;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int errTotal = 0;
    int totalChecks = 0;
    logic [31:0] rng = 32'h86DFF3F1;
    logic [7:0] enA[4] = '{8'h84, 8'h88, 8'h8C, 8'hB0};
    logic [7:0] flA[4] = '{8'h94, 8'h98, 8'h9C, 8'h90};
    logic [7:0] seA[4] = '{8'hA4, 8'hA8, 8'hAC, 8'hA0};
    localparam logic [1:0] OK = isr_pkg::RESP_OKAY;

    isr_routing DUT (.ref_clk(ref_clk), .rst(rst), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .eventLevel(ev),
        .interruptPinA_n(pinA_n), .interruptPinB_n(pinB_n));

    isr_host_model HOST (.ref_clk(ref_clk), .rst(rst), .pinA_n(pinA_n), .pinB_n(pinB_n),
        .pending(pend));

    // free-running 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] nextRand(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic cmpWord(input string nm, input logic [33:0] exp, input logic [33:0] got);
        totalChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cmpPins(input logic [1:0] exp);
        totalChecks++;
        if (pend !== exp) begin
            errTotal++;
            $display("[FAIL] pins pending expected %b seen %b", exp, pend);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // write one register, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw;
        logic w;
        bq.push_back(er);
        aw = 1'b0;
        w = 1'b0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge ref_clk);
            if (awvalid && awready) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        @(posedge ref_clk);
    endtask

    // read one register, expected answer queued first
    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        rq.push_back({er, 24'h000000, ed});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge ref_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        @(posedge ref_clk);
    endtask

    // monitor: each bus answer against the oldest note
    always @(posedge ref_clk) begin
        if (rvalid && rready) begin
            cmpWord("read answer", rq.pop_front(), {rresp, rdata});
        end
        if (bvalid && bready) begin
            cmpWord("write answer", {32'h00000000, bq.pop_front()}, {32'h00000000, bresp});
        end
    end

    // one event: live while disabled, then latched, routed and cleared
    task automatic latchRun(input int g, input int b, input logic s);
        logic [7:0] m;
        logic [1:0] p;
        m = 8'h01 << b;
        p = s ? 2'b10 : 2'b01;
        ev <= '0;
        cyc(8);
        wr(seA[g], s ? m : 8'h00, OK);
        ev[g * 8 + b] <= 1'b1;
        cyc(8);
        cmpPins(2'b00);
        rd(flA[g], m, OK);
        ev[g * 8 + b] <= 1'b0;
        cyc(8);
        wr(enA[g], m, OK);
        ev[g * 8 + b] <= 1'b1;
        cyc(8);
        cmpPins(p);
        ev[g * 8 + b] <= 1'b0;
        cyc(8);
        rd(flA[g], m, OK);
        wr(flA[g], 8'h00, OK);
        rd(flA[g], m, OK);
        cmpPins(p);
        wr(flA[g], m, OK);
        cyc(2);
        cmpPins(2'b00);
        rd(flA[g], 8'h00, OK);
        wr(enA[g], 8'h00, OK);
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        cyc(3);
        rst <= 1'b0;
        cyc(2);
        for (int i = 0; i < 4; i++) begin
            rd(enA[i], 8'h00, OK);
            rd(flA[i], 8'h00, OK);
            rd(seA[i], 8'h00, OK);
        end
        cmpPins(2'b00);
        rd(8'h80, 8'h00, isr_pkg::RESP_SLVERR);
        wr(8'hFC, 8'h55, isr_pkg::RESP_SLVERR);
        wr(seA[3], 8'hFF, OK);
        rd(seA[3], 8'h1F, OK);
        // a write without byte lane 0 answers but stores nothing
        wstrb <= 4'h0;
        wr(seA[3], 8'h00, OK);
        wstrb <= 4'hF;
        rd(seA[3], 8'h1F, OK);
        // random live levels with every enable low
        for (int k = 0; k < 4; k++) begin
            rng = nextRand(rng);
            ev <= isr_pkg::isr_grp_t'(rng);
            cyc(8);
            for (int g = 0; g < 4; g++) begin
                rd(flA[g], rng[g * 8 +: 8] & isr_pkg::GRP_MASK[g * 8 +: 8], OK);
            end
            cmpPins(2'b00);
        end
        for (int g = 0; g < 4; g++) begin
            for (int b = 0; b < 8; b++) begin
                if (isr_pkg::GRP_MASK[g * 8 + b]) begin
                    latchRun(g, b, b[0]);
                end
            end
        end
        // two flags on one pin, released only after both clear
        wr(seA[2], 8'h00, OK);
        wr(enA[2], 8'h03, OK);
        ev <= isr_pkg::isr_grp_t'(32'h00030000);
        cyc(8);
        cmpPins(2'b01);
        wr(flA[2], 8'h01, OK);
        cyc(2);
        cmpPins(2'b01);
        wr(flA[2], 8'h02, OK);
        cyc(2);
        cmpPins(2'b00);
        conclude();
    end

    // watchdog well beyond the expected run length
    initial begin
        cyc(30000);
        errTotal++;
        $display("[FAIL] run length expected finish seen timeout");
        conclude();
    end
endmodule // irq_status_routing_tb
`default_nettype wire
